// file: hw/mcie_core.sv
`timescale 1ns/100ps
`include "mcie_params.svh"

module mcie_core (
  input wire logic clock_i,
  input wire logic arst_n_i,
  output logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  output logic [7:0] data_addr_o,
  input wire logic [7:0] data_rdata_i,
  output logic [7:0] data_wdata_o,
  output logic data_we_o,
  input wire logic wdog_sel_i,
  input wire logic wake_i,
  output logic fetch_o,
  output logic wait_mode_o,
  output logic stop_mode_o,
  output logic [7:0] acc_o,
  output logic zero_flag_o,
  output logic carry_flag_o
);

  mcie_pkg::mcie_core_t q;
  mcie_pkg::mcie_core_t d;

  mcie_pkg::mcie_class_t cls;
  mcie_pkg::mcie_fn_t fn;
  logic [1:0] nbytes;
  logic [2:0] ncyc;
  logic am_ind;
  logic am_short;
  logic to_acc;
  logic to_mem;
  logic upd_z;
  logic upd_c;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_z;
  logic [7:0] rd;
  logic [7:0] bit_val;
  logic [2:0] bidx;
  logic tbit;
  logic exec;
  logic wr_en;
  logic [7:0] wr_val;
  logic rel_go;
  logic [3:0] lo;
  logic [3:0] hi;

  assign lo = q.op[3:0];
  assign hi = q.op[7:4];
  assign bidx = q.op[7:5]; // RQ12
  assign rd = (q.daddr == `MCIE_ACC_ADDR) ? q.acc : data_rdata_i;
  assign tbit = rd[bidx];

  // ==========================================
  // bit set and clear, one lane per bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign bit_val[gi] = (bidx == 3'(gi)) ? q.op[4] : rd[gi]; // RQ11
    end
  endgenerate

  // ==========================================
  // decode
  always_comb begin
    cls = mcie_pkg::CL_CTRL;
    fn = mcie_pkg::FN_ADD;
    nbytes = `MCIE_LEN_1;
    ncyc = `MCIE_CYC_CTRL; // RQ13
    am_ind = 1'b0;
    am_short = 1'b0;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    alu_a = q.acc; // RQ1
    alu_b = rd;
    if (!q.op[0]) begin
      cls = mcie_pkg::CL_REL;
      ncyc = `MCIE_CYC_REL; // RQ6
    end else begin
      case (lo)
        `MCIE_LO_CALL: begin
          cls = mcie_pkg::CL_CALL;
          nbytes = `MCIE_LEN_2;
          ncyc = `MCIE_CYC_JMP;
        end
        `MCIE_LO_JUMP: begin
          cls = mcie_pkg::CL_JMP;
          nbytes = `MCIE_LEN_2;
          ncyc = `MCIE_CYC_JMP;
        end
        `MCIE_LO_BTST: begin
          cls = mcie_pkg::CL_BTST;
          nbytes = `MCIE_LEN_3; // RQ8
          ncyc = `MCIE_CYC_BTST;
        end
        `MCIE_LO_BSET: begin
          cls = mcie_pkg::CL_BSET;
          nbytes = `MCIE_LEN_2; // RQ11
          ncyc = `MCIE_CYC_BSET;
        end
        `MCIE_LO_DIR, `MCIE_LO_INDX, `MCIE_LO_INDY: begin
          cls = mcie_pkg::CL_ALU;
          ncyc = `MCIE_CYC_ALU; // RQ4
          am_ind = (lo != `MCIE_LO_DIR);
          nbytes = am_ind ? `MCIE_LEN_1 : `MCIE_LEN_2; // RQ5
          if (!am_ind && q.op[7]) begin
            // short direct plus/minus one on the four work registers
            am_short = 1'b1;
            nbytes = `MCIE_LEN_1; // RQ5
            fn = q.op[6] ? mcie_pkg::FN_MINUS : mcie_pkg::FN_INC;
            alu_a = rd;
            to_mem = 1'b1;
            upd_z = 1'b1; // RQ5
          end else begin
            case (hi)
              `MCIE_HI_ADD: begin
                to_acc = 1'b1; // RQ1
                upd_z = 1'b1;
                upd_c = 1'b1; // RQ4
              end
              `MCIE_HI_AND: begin
                fn = mcie_pkg::FN_AND;
                to_acc = 1'b1; // RQ1
                upd_z = 1'b1;
                upd_c = 1'b1; // RQ4
              end
              `MCIE_HI_CMP: begin
                fn = mcie_pkg::FN_SUB;
                upd_z = 1'b1;
                upd_c = 1'b1; // RQ4
              end
              `MCIE_HI_SUB: begin
                fn = mcie_pkg::FN_SUB;
                to_acc = 1'b1; // RQ1
                upd_z = 1'b1;
                upd_c = 1'b1; // RQ4
              end
              `MCIE_HI_INC, `MCIE_HI_MINUS: begin
                fn = (hi == `MCIE_HI_MINUS) ? mcie_pkg::FN_MINUS : mcie_pkg::FN_INC;
                alu_a = rd; // RQ2
                to_mem = 1'b1;
                upd_z = 1'b1; // RQ5
              end
              `MCIE_HI_ZERO: begin
                fn = mcie_pkg::FN_ZERO;
                to_mem = 1'b1; // RQ2
                nbytes = am_ind ? `MCIE_LEN_1 : `MCIE_LEN_3; // RQ5
              end
              default: begin
                fn = mcie_pkg::FN_ADD;
              end
            endcase
          end
        end
        `MCIE_LO_INH: begin
          if (hi <= `MCIE_HI_ZERO_ACC) begin
            cls = mcie_pkg::CL_ALU;
            ncyc = `MCIE_CYC_ALU; // RQ4
            alu_b = q.b1; // RQ1
            to_acc = (hi != `MCIE_HI_CMP_IMM);
            upd_z = 1'b1;
            upd_c = 1'b1; // RQ4
            nbytes = `MCIE_LEN_2;
            case (hi)
              `MCIE_HI_AND_IMM: fn = mcie_pkg::FN_AND;
              `MCIE_HI_CMP_IMM, `MCIE_HI_SUB_IMM: fn = mcie_pkg::FN_SUB;
              `MCIE_HI_INVERT: begin
                fn = mcie_pkg::FN_INVERT; // RQ3
                nbytes = `MCIE_LEN_1;
              end
              `MCIE_HI_ROTATE: begin
                fn = mcie_pkg::FN_ROTATE; // RQ3
                nbytes = `MCIE_LEN_1;
              end
              `MCIE_HI_SHIFT: fn = mcie_pkg::FN_SHIFT; // RQ3
              `MCIE_HI_ZERO_ACC: fn = mcie_pkg::FN_ZERO;
              default: fn = mcie_pkg::FN_ADD;
            endcase
          end
        end
        default: begin
          cls = mcie_pkg::CL_CTRL;
        end
      endcase
    end
  end

  mcie_alu mcie_alu_inst (
    .fn_i(fn),
    .a_i(alu_a),
    .b_i(alu_b),
    .cin_i(q.c),
    .res_o(alu_res),
    .cout_o(alu_c),
    .z_o(alu_z)
  );

  // ==========================================
  // execute qualifiers
  assign exec = (q.st == mcie_pkg::ST_RUN) && (q.cyc != 3'h0) && (q.cyc == ncyc - 3'h1);
  assign wr_en = exec && (((cls == mcie_pkg::CL_ALU) && to_mem) || (cls == mcie_pkg::CL_BSET));
  assign wr_val = (cls == mcie_pkg::CL_BSET) ? bit_val : alu_res;

  always_comb begin
    case (q.op[2:0])
      `MCIE_REL_NZ: rel_go = !q.z;
      `MCIE_REL_NC: rel_go = !q.c;
      `MCIE_REL_Z: rel_go = q.z;
      `MCIE_REL_C: rel_go = q.c; // RQ6
      default: rel_go = 1'b0;
    endcase
  end

  // ==========================================
  // sequencer
  always_comb begin
    d = q;
    d.we = 1'b0;
    d.wd_meta = wdog_sel_i;
    d.wd_sync = q.wd_meta;
    case (q.st)
      mcie_pkg::ST_RUN: begin
        d.cyc = q.cyc + 3'h1;
        if (q.cyc == 3'h0) begin
          d.op = prog_data_i;
          d.ipc = q.pc;
          d.pc = q.pc + 12'h001;
        end
        if (q.cyc == 3'h1) begin
          if (nbytes >= `MCIE_LEN_2) begin
            d.b1 = prog_data_i;
            d.pc = q.pc + 12'h001;
          end
          if (am_ind) begin
            d.daddr = `MCIE_PTR_X_ADDR | {7'h00, q.op[3]};
          end else if (am_short) begin
            d.daddr = {`MCIE_SHORT_BASE, q.op[5:4]};
          end else begin
            d.daddr = prog_data_i; // RQ2
          end
        end
        if (q.cyc == 3'h2) begin
          if (nbytes == `MCIE_LEN_3) begin
            d.b2 = prog_data_i;
            d.pc = q.pc + 12'h001;
          end
          if (am_ind) begin
            d.daddr = data_rdata_i; // RQ1
          end
        end
        if (exec) begin
          d.cyc = 3'h0;
          case (cls)
            mcie_pkg::CL_ALU: begin
              if (to_acc) begin
                d.acc = alu_res;
              end
              if (upd_z) begin
                d.z = alu_z; // RQ16
              end
              if (upd_c) begin
                d.c = alu_c; // RQ16
              end
            end
            mcie_pkg::CL_REL: begin
              if (rel_go) begin
                d.pc = q.ipc + `MCIE_REL_BASE + {{7{q.op[7]}}, q.op[7:3]}; // RQ7
              end
            end
            mcie_pkg::CL_BTST: begin
              d.c = tbit; // RQ10
              if (tbit == q.op[4]) begin
                d.pc = q.ipc + `MCIE_BTST_BASE + {{4{q.b2[7]}}, q.b2}; // RQ9
              end
            end
            mcie_pkg::CL_JMP: begin
              d.pc = {hi, q.b1}; // RQ14
            end
            mcie_pkg::CL_CALL: begin
              d.pc = {hi, q.b1}; // RQ14
              d.stk = {q.stk[`MCIE_STACK_DEPTH-2:0], q.z, q.c, q.pc};
            end
            mcie_pkg::CL_CTRL: begin
              case (hi)
                `MCIE_HI_EXIT_SUB, `MCIE_HI_EXIT_INT: begin
                  d.pc = q.stk[0][11:0];
                  d.stk = {q.stk[`MCIE_STACK_DEPTH-1], q.stk[`MCIE_STACK_DEPTH-1:1]};
                  if (hi == `MCIE_HI_EXIT_INT) begin
                    d.z = q.stk[0][13]; // RQ13
                    d.c = q.stk[0][12];
                  end
                end
                `MCIE_HI_STOP: begin
                  d.st = q.wd_sync ? mcie_pkg::ST_WAIT : mcie_pkg::ST_STOP; // RQ15
                end
                `MCIE_HI_WAIT: begin
                  d.st = mcie_pkg::ST_WAIT;
                end
                default: begin
                  d.st = mcie_pkg::ST_RUN;
                end
              endcase
            end
            default: begin
              d.cyc = 3'h0;
            end
          endcase
          if (wr_en) begin
            if (q.daddr == `MCIE_ACC_ADDR) begin
              d.acc = wr_val;
            end else begin
              d.we = 1'b1;
              d.wdata = wr_val;
            end
          end
        end
      end
      mcie_pkg::ST_WAIT, mcie_pkg::ST_STOP: begin
        if (wake_i) begin
          d.st = mcie_pkg::ST_RUN;
          d.cyc = 3'h0;
        end
      end
      default: begin
        d.st = mcie_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.pc <= `MCIE_RESET_PC;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  assign prog_addr_o = q.pc;
  assign data_addr_o = q.daddr;
  assign data_wdata_o = q.wdata;
  assign data_we_o = q.we;
  assign acc_o = q.acc;
  assign zero_flag_o = q.z;
  assign carry_flag_o = q.c;
  assign fetch_o = (q.st == mcie_pkg::ST_RUN) && (q.cyc == 3'h0);
  assign wait_mode_o = (q.st == mcie_pkg::ST_WAIT);
  assign stop_mode_o = (q.st == mcie_pkg::ST_STOP);

endmodule

// file: hw/mcie_params.svh
// Overview of operation
// RQ1: add, and, compare, subtract take the accumulator and a memory or immediate operand.
// RQ2: zero fill, minus one, plus one accept any of 256 data addresses.
// RQ3: invert, rotate through carry, shift left work on the accumulator only.
// RQ4: arithmetic and logic take 4 cycles; accumulator forms update zero and carry.
// RQ5: increment and decrement touch zero only; register zero fill touches no flag.
// RQ6: flag branches are one byte, 2 cycles, branch on condition, keep flags.
// RQ7: flag branches use 5-bit signed displacement, range -15 to +16.
// RQ8: bit-test branches are 3 bytes, 5 cycles, branch on bit, keep zero.
// RQ9: bit-test branches use 8-bit signed displacement, range -126 to +129.
// RQ10: bit-test branches copy the tested bit into carry, taken or not.
// RQ11: bit set and clear reach any data bit, 2 bytes, 4 cycles, keep flags.
// RQ12: a 3-bit index selects the bit within the addressed byte.
// RQ13: control instructions are one byte, 2 cycles; only interrupt exit changes flags.
// RQ14: long jump and call carry a 12-bit target over the whole program space.
// RQ15: with watchdog selected, stop executes as wait.
// RQ16: zero flag means 8-bit result zero; carry is carry or borrow out of bit 7.
`ifndef MCIE_PARAMS_SVH
`define MCIE_PARAMS_SVH

// ==========================================
// data space map
`define MCIE_ACC_ADDR 8'hff
`define MCIE_PTR_X_ADDR 8'h80
`define MCIE_SHORT_BASE 6'h20
`define MCIE_RESET_PC 12'h000
`define MCIE_STACK_DEPTH 6

// ==========================================
// opcode low nibble groups
`define MCIE_LO_CALL 4'h1
`define MCIE_LO_JUMP 4'h9
`define MCIE_LO_BTST 4'h3
`define MCIE_LO_BSET 4'hb
`define MCIE_LO_DIR 4'h5
`define MCIE_LO_INDX 4'h7
`define MCIE_LO_INDY 4'hf
`define MCIE_LO_INH 4'hd

// relative branch conditions, opcode bits 2..0
`define MCIE_REL_NZ 3'h0
`define MCIE_REL_NC 3'h2
`define MCIE_REL_Z 3'h4
`define MCIE_REL_C 3'h6

// high nibble, memory operand groups
`define MCIE_HI_ADD 4'h0
`define MCIE_HI_AND 4'h1
`define MCIE_HI_CMP 4'h2
`define MCIE_HI_SUB 4'h3
`define MCIE_HI_INC 4'h4
`define MCIE_HI_MINUS 4'h5
`define MCIE_HI_ZERO 4'h6

// high nibble, inherent and immediate group
`define MCIE_HI_ADD_IMM 4'h0
`define MCIE_HI_AND_IMM 4'h1
`define MCIE_HI_CMP_IMM 4'h2
`define MCIE_HI_SUB_IMM 4'h3
`define MCIE_HI_INVERT 4'h4
`define MCIE_HI_ROTATE 4'h5
`define MCIE_HI_SHIFT 4'h6
`define MCIE_HI_ZERO_ACC 4'h7
`define MCIE_HI_IDLE 4'h8
`define MCIE_HI_EXIT_SUB 4'h9
`define MCIE_HI_EXIT_INT 4'ha
`define MCIE_HI_STOP 4'hb
`define MCIE_HI_WAIT 4'hc

// ==========================================
// lengths and cycle counts
`define MCIE_LEN_1 2'h1
`define MCIE_LEN_2 2'h2
`define MCIE_LEN_3 2'h3
`define MCIE_CYC_ALU 3'h4
`define MCIE_CYC_REL 3'h2
`define MCIE_CYC_BTST 3'h5
`define MCIE_CYC_BSET 3'h4
`define MCIE_CYC_CTRL 3'h2
`define MCIE_CYC_JMP 3'h4

// branch bases from instruction address
`define MCIE_REL_BASE 12'h001
`define MCIE_BTST_BASE 12'h002

`endif

// file: hw/mcie_pkg.sv
`include "mcie_params.svh"

package mcie_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10
  } mcie_state_t;

  typedef enum logic [2:0] {
    CL_CTRL = 3'b000,
    CL_REL = 3'b001,
    CL_ALU = 3'b010,
    CL_BTST = 3'b011,
    CL_BSET = 3'b100,
    CL_JMP = 3'b101,
    CL_CALL = 3'b110
  } mcie_class_t;

  typedef enum logic [3:0] {
    FN_ADD = 4'b0000,
    FN_AND = 4'b0001,
    FN_SUB = 4'b0010,
    FN_INC = 4'b0011,
    FN_MINUS = 4'b0100,
    FN_INVERT = 4'b0101,
    FN_ROTATE = 4'b0110,
    FN_SHIFT = 4'b0111,
    FN_ZERO = 4'b1000
  } mcie_fn_t;

  typedef struct packed {
    mcie_state_t st;
    logic [2:0] cyc;
    logic [11:0] pc;
    logic [11:0] ipc;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] daddr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] acc;
    logic z;
    logic c;
    logic [`MCIE_STACK_DEPTH-1:0][13:0] stk;
    logic wd_meta;
    logic wd_sync;
  } mcie_core_t;

endpackage

// file: hw/mcie_alu.sv
`timescale 1ns/100ps

module mcie_alu (
  input wire mcie_pkg::mcie_fn_t fn_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  output logic [7:0] res_o,
  output logic cout_o,
  output logic z_o
);

  logic [8:0] wide;

  // ==========================================
  // result and carry out of bit 7
  always_comb begin
    wide = 9'h000;
    res_o = 8'h00;
    cout_o = 1'b0;
    case (fn_i)
      mcie_pkg::FN_ADD: begin
        wide = {1'b0, a_i} + {1'b0, b_i};
        res_o = wide[7:0];
        cout_o = wide[8]; // RQ16
      end
      mcie_pkg::FN_AND: begin
        res_o = a_i & b_i;
      end
      mcie_pkg::FN_SUB: begin
        wide = {1'b0, a_i} - {1'b0, b_i};
        res_o = wide[7:0];
        cout_o = wide[8]; // RQ16
      end
      mcie_pkg::FN_INC: begin
        res_o = a_i + 8'h01;
      end
      mcie_pkg::FN_MINUS: begin
        res_o = a_i - 8'h01;
      end
      mcie_pkg::FN_INVERT: begin
        res_o = ~a_i;
        cout_o = a_i[7];
      end
      mcie_pkg::FN_ROTATE: begin
        res_o = {a_i[6:0], cin_i};
        cout_o = a_i[7];
      end
      mcie_pkg::FN_SHIFT: begin
        res_o = {a_i[6:0], 1'b0};
        cout_o = a_i[7];
      end
      mcie_pkg::FN_ZERO: begin
        res_o = 8'h00;
      end
      default: begin
        res_o = a_i;
      end
    endcase
  end

  assign z_o = (res_o == 8'h00); // RQ16

endmodule

// file: test/mcie_mem_model.sv
`timescale 1ns/100ps

// ==========================================
// program rom and data space, both read combinationally
module mcie_mem_model (
  input wire logic clock_i,
  input wire logic [11:0] prog_addr_i,
  output logic [7:0] prog_data_o,
  input wire logic [7:0] data_addr_i,
  output logic [7:0] data_rdata_o,
  input wire logic [7:0] data_wdata_i,
  input wire logic data_we_i
);
  logic [7:0] pmem [4096];
  logic [7:0] dmem [256];

  assign prog_data_o = pmem[prog_addr_i];
  assign data_rdata_o = dmem[data_addr_i];

  // plain always: the bench also presets cells
  always @(posedge clock_i) begin
    if (data_we_i) begin
      dmem[data_addr_i] <= data_wdata_i;
    end
  end
endmodule

// file: test/mcie_core_sva.sv
`timescale 1ns/100ps

module mcie_core_sva (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [11:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  input wire logic wdog_sel_i,
  input wire logic fetch_o,
  input wire logic wait_mode_o,
  input wire logic stop_mode_o,
  input wire logic zero_flag_o,
  input wire logic carry_flag_o
);
  // ==========================================
  // opcode fetch while running
  logic run_fetch;
  assign run_fetch = fetch_o && !wait_mode_o && !stop_mode_o;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_two;
    !fetch_o ##1 fetch_o;
  endsequence
  sequence s_four;
    !fetch_o [*3] ##1 fetch_o;
  endsequence
  sequence s_five;
    !fetch_o [*4] ##1 fetch_o;
  endsequence

  AST_ALU_FOUR: assert property (run_fetch && (prog_data_i[3:0] inside {4'h5, 4'h7, 4'hf} ||
    (prog_data_i[3:0] == 4'hd && !prog_data_i[7])) |=> s_four)
    else $error("alu instruction not four cycles");
  AST_REL_TWO: assert property (run_fetch && !prog_data_i[0] |=> s_two)
    else $error("flag branch not two cycles");
  AST_REL_FLAGS: assert property (run_fetch && !prog_data_i[0] |=>
    ($stable(zero_flag_o) && $stable(carry_flag_o)) [*2])
    else $error("flag branch changed a flag");
  AST_BTST_FIVE: assert property (run_fetch && prog_data_i[3:0] == 4'h3 |=> s_five
    and $stable(zero_flag_o) [*5])
    else $error("bit test branch timing or zero flag wrong");
  AST_BSET_FOUR: assert property (run_fetch && prog_data_i[3:0] == 4'hb |=> s_four
    and ($stable(zero_flag_o) && $stable(carry_flag_o)) [*4])
    else $error("bit set or clear timing or flags wrong");
  AST_INCDEC_CARRY: assert property (run_fetch && prog_data_i inside {8'h45, 8'h55} |=>
    $stable(carry_flag_o) [*4])
    else $error("increment or decrement changed carry");
  AST_IDLE_TWO: assert property (run_fetch && prog_data_i == 8'h8d |=> s_two)
    else $error("idle instruction not two cycles");
  AST_JUMP_TARGET: assert property (run_fetch && prog_data_i[3:0] inside {4'h1, 4'h9} |->
    ##4 fetch_o && prog_addr_o == {$past(prog_data_i[7:4], 4), $past(prog_data_i, 3)})
    else $error("long jump or call target wrong");
  AST_WAIT_ENTRY: assert property (run_fetch && prog_data_i == 8'hcd |-> ##[1:2] wait_mode_o)
    else $error("wait not entered");
  AST_STOP_AS_WAIT: assert property (run_fetch && prog_data_i == 8'hbd && wdog_sel_i &&
    $past(wdog_sel_i) |-> ##[1:2] (wait_mode_o && !stop_mode_o))
    else $error("stop not turned into wait");
  AST_STOP_ENTRY: assert property (run_fetch && prog_data_i == 8'hbd && !wdog_sel_i &&
    !$past(wdog_sel_i) |-> ##[1:2] (stop_mode_o && !wait_mode_o))
    else $error("stop not entered");
endmodule

bind mcie_core mcie_core_sva mcie_core_sva_inst (
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .prog_addr_o(prog_addr_o),
  .prog_data_i(prog_data_i),
  .wdog_sel_i(wdog_sel_i),
  .fetch_o(fetch_o),
  .wait_mode_o(wait_mode_o),
  .stop_mode_o(stop_mode_o),
  .zero_flag_o(zero_flag_o),
  .carry_flag_o(carry_flag_o)
);

// file: test/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  typedef struct {logic [7:0] op, b, a, acc; logic z, c;} mcie_row_t;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wdog_sel_i = 1'b0;
  logic wake_i = 1'b0;
  logic [11:0] prog_addr_o;
  logic [7:0] prog_data_i, data_addr_o, data_rdata_i, data_wdata_o, acc_o;
  logic data_we_o, fetch_o, wait_mode_o, stop_mode_o, zero_flag_o, carry_flag_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  mcie_row_t rows [11] = '{'{8'h0d, 8'h20, 8'hf0, 8'h10, 1'b0, 1'b1}, '{8'h0d, 8'h01, 8'hff, 8'h00, 1'b1, 1'b1},
    '{8'h1d, 8'h0f, 8'hf0, 8'h00, 1'b1, 1'b0}, '{8'h2d, 8'h20, 8'h10, 8'h10, 1'b0, 1'b1},
    '{8'h2d, 8'h33, 8'h33, 8'h33, 1'b1, 1'b0}, '{8'h3d, 8'h10, 8'h50, 8'h40, 1'b0, 1'b0},
    '{8'h4d, 8'h8d, 8'hff, 8'h00, 1'b1, 1'b1}, '{8'h5d, 8'h8d, 8'h81, 8'h02, 1'b0, 1'b1},
    '{8'h6d, 8'h00, 8'h80, 8'h00, 1'b1, 1'b1}, '{8'h7d, 8'h00, 8'h55, 8'h00, 1'b1, 1'b0},
    '{8'h05, 8'h40, 8'h01, 8'h00, 1'b1, 1'b1}};

  always #25 clock_i = ~clock_i;

  mcie_core mcie_core_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .prog_addr_o(prog_addr_o),
    .prog_data_i(prog_data_i), .data_addr_o(data_addr_o), .data_rdata_i(data_rdata_i),
    .data_wdata_o(data_wdata_o), .data_we_o(data_we_o), .wdog_sel_i(wdog_sel_i), .wake_i(wake_i),
    .fetch_o(fetch_o), .wait_mode_o(wait_mode_o), .stop_mode_o(stop_mode_o), .acc_o(acc_o),
    .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o));

  mcie_mem_model mcie_mem_model_inst (.clock_i(clock_i), .prog_addr_i(prog_addr_o),
    .prog_data_o(prog_data_i), .data_addr_i(data_addr_o), .data_rdata_o(data_rdata_i),
    .data_wdata_i(data_wdata_o), .data_we_i(data_we_o));

  // ==========================================
  // checking and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp, input string what);
    chk_byte(got[11:4], exp[11:4], what);
    chk_byte({4'h0, got[3:0]}, {4'h0, exp[3:0]}, what);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc_cnt++;
    if (cyc_cnt >= 5000) begin
      error_cnt++;
      $display("mismatch at %0t: run too long", $time);
      end_sim();
    end
  end

  // ==========================================
  // stimulus helpers
  task automatic put(input int at, input logic [7:0] q[$]);
    foreach (q[i]) mcie_mem_model_inst.pmem[at + i] = q[i];
  endtask

  task automatic do_reset();
    @(negedge clock_i);
    arst_n_i = 1'b0;
    repeat (20) @(negedge clock_i);
    chk_addr(prog_addr_o, 12'h000, "reset pc");
    chk_byte(acc_o, 8'h00, "reset acc");
    chk_bit(zero_flag_o | carry_flag_o | data_we_o, 1'b0, "reset flags");
    arst_n_i = 1'b1;
  endtask

  task automatic wait_halt();
    int n;
    n = 0;
    @(negedge clock_i);
    while (wait_mode_o !== 1'b1 && stop_mode_o !== 1'b1 && n < 60) begin
      @(negedge clock_i);
      n++;
    end
    chk_bit(n < 60, 1'b1, "halt reached");
  endtask

  task automatic wake();
    wake_i = 1'b1;
    @(negedge clock_i);
    wake_i = 1'b0;
    wait_halt();
  endtask

  // ==========================================
  // main sequence
  initial begin
    mcie_mem_model_inst.dmem[8'h40] = 8'hff;
    foreach (rows[i]) begin
      put(0, '{8'h7d, 8'h00, 8'h0d, rows[i].a, rows[i].op, rows[i].b, 8'hcd});
      do_reset();
      wait_halt();
      chk_byte(acc_o, rows[i].acc, "alu result");
      chk_bit(zero_flag_o, rows[i].z, "alu zero");
      chk_bit(carry_flag_o, rows[i].c, "alu carry");
      $display("test alu row %0d done", i);
    end
    // increment, bit set, bit test branch, long jump, flag branch, halts
    mcie_mem_model_inst.dmem[8'h10] = 8'hff;
    mcie_mem_model_inst.dmem[8'h11] = 8'h00;
    put(0, '{8'h45, 8'h10, 8'h7b, 8'h11, 8'h73, 8'h11, 8'h02, 8'hcd, 8'h09, 8'h20});
    put(12'h020, '{8'h16, 8'hcd, 8'hcd, 8'hcd, 8'hbd, 8'hbd});
    do_reset();
    wait_halt();
    chk_byte(mcie_mem_model_inst.dmem[8'h10], 8'h00, "increment wraps");
    chk_byte(mcie_mem_model_inst.dmem[8'h11], 8'h08, "bit three set");
    chk_bit(carry_flag_o, 1'b1, "tested bit in carry");
    chk_bit(zero_flag_o, 1'b1, "zero kept");
    chk_addr(prog_addr_o, 12'h024, "taken branches");
    chk_bit(wait_mode_o, 1'b1, "wait entered");
    $display("test branch chain done");
    wake();
    chk_bit(stop_mode_o, 1'b1, "stop entered");
    wdog_sel_i = 1'b1;
    repeat (4) @(negedge clock_i);
    wake();
    chk_bit(wait_mode_o & ~stop_mode_o, 1'b1, "stop acts as wait");
    chk_addr(prog_addr_o, 12'h026, "pc after halts");
    $display("test halt modes done");
    // indirect add, short decrement, register clear, call and interrupt exit, bit clear
    mcie_mem_model_inst.dmem[8'h80] = 8'h30;
    mcie_mem_model_inst.dmem[8'h30] = 8'h05;
    mcie_mem_model_inst.dmem[8'h82] = 8'h02;
    mcie_mem_model_inst.dmem[8'h50] = 8'h77;
    put(0, '{8'h0d, 8'h01, 8'h07, 8'he5, 8'h65, 8'h50, 8'h99, 8'h31, 8'h40, 8'h1e, 8'h0b, 8'h30, 8'h03, 8'h30,
      8'h03, 8'hcd, 8'hcd, 8'hcd});
    put(12'h340, '{8'h2d, 8'h07, 8'had});
    do_reset();
    wait_halt();
    chk_byte(acc_o, 8'h06, "indirect add");
    chk_byte(mcie_mem_model_inst.dmem[8'h82], 8'h01, "short decrement");
    chk_byte(mcie_mem_model_inst.dmem[8'h50], 8'h00, "register clear");
    chk_byte(mcie_mem_model_inst.dmem[8'h30], 8'h04, "bit zero cleared");
    chk_bit(zero_flag_o, 1'b0, "register clear keeps zero");
    chk_bit(carry_flag_o, 1'b0, "cleared bit in carry");
    chk_addr(prog_addr_o, 12'h012, "call, exit and branches");
    $display("test call chain done");
    end_sim();
  end
endmodule
